/* include/dsp_consts.svh */
`ifndef DSP_CONSTS_SVH
`define DSP_CONSTS_SVH

// geometry of the 18-bit port
`define DSP_ADDR_W 21
`define DSP_DATA_W 18
`define DSP_LANE_W 9
`define DSP_LANES 2
`define DSP_BEAT_W 2

// burst beat numbers (low burst-address bits)
`define DSP_BEAT0 2'h0
`define DSP_BEAT1 2'h1
`define DSP_BEAT2 2'h2
`define DSP_BEAT3 2'h3

// burst step counter values
`define DSP_STEP_IDLE 2'h0
`define DSP_STEP_FIRST 2'h1
`define DSP_STEP_SECOND 2'h2

// delay-locked loop lock time in clock cycles
`define DSP_LOCK_CYCLES 12'h800
`define DSP_LOCK_W 12

// impedance evaluation terminal count (one evaluation every 1024 clock cycles) and driver code
`define DSP_IMP_PERIOD 10'h3ff
`define DSP_IMP_CNT_W 10
`define DSP_IMP_CODE_W 6
`define DSP_IMP_CODE_MIN_Z 6'h3f
`define DSP_IMP_CODE_RST 6'h20

`endif

/* include/dsp_pkg.sv */
package dsp_pkg;

  typedef enum logic [1:0] {
    DSP_CMD_DESELECT,
    DSP_CMD_READ,
    DSP_CMD_WRITE
  } dsp_cmd_t;

endpackage : dsp_pkg

/* logic/dsp_sram_port.sv */
`timescale 1ns/1ps
`include "dsp_consts.svh"

module dsp_sram_port
  import dsp_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic [`DSP_ADDR_W-1:0] sync_word_location_i,
  input wire logic load_fetch_n_i,
  input wire logic store_select_n_i,
  input wire logic [`DSP_DATA_W-1:0] input_beats_main_i,
  input wire logic [`DSP_DATA_W-1:0] input_beats_comp_i,
  input wire logic [`DSP_LANES-1:0] lane_store_masks_main_n_i,
  input wire logic [`DSP_LANES-1:0] lane_store_masks_comp_n_i,
  input wire logic timing_loop_off_n_i,
  input wire logic impedance_ref_pin_i,
  input wire logic [`DSP_IMP_CODE_W-1:0] impedance_target_i,
  output logic [`DSP_DATA_W-1:0] output_beats_comp_o,
  output logic [`DSP_DATA_W-1:0] output_beats_main_o,
  output logic output_beats_oe_o,
  output logic output_valid_flag_o,
  output logic timing_loop_locked_o,
  output logic [`DSP_IMP_CODE_W-1:0] drive_code_o
);

  localparam int unsigned DEPTH = 2 ** (`DSP_ADDR_W + `DSP_BEAT_W);

  function automatic logic [`DSP_ADDR_W+`DSP_BEAT_W-1:0] beat_index(
    input logic [`DSP_ADDR_W-1:0] base,
    input logic [`DSP_BEAT_W-1:0] beat
  );
    beat_index = {base, beat};
  endfunction : beat_index

  dsp_cmd_t prev_cmd_reg;
  dsp_cmd_t cmd_next;
  logic rd_go;
  logic wr_go;
  logic [`DSP_ADDR_W-1:0] rd_addr_reg;
  logic [`DSP_ADDR_W-1:0] wr_addr_reg;
  logic [1:0] rd_step_reg;
  logic [1:0] wr_step_reg;
  logic [`DSP_BEAT_W-1:0] rd_beat_a;
  logic [`DSP_BEAT_W-1:0] rd_beat_b;
  logic [`DSP_BEAT_W-1:0] wr_beat_a;
  logic [`DSP_BEAT_W-1:0] wr_beat_b;
  logic [`DSP_LANE_W-1:0] q_comp_reg [`DSP_LANES];
  logic [`DSP_LANE_W-1:0] q_main_reg [`DSP_LANES];
  logic oe_reg;
  logic valid_reg;
  logic loop_meta_reg;
  logic loop_sync_reg;
  logic zq_meta_reg;
  logic zq_sync_reg;
  logic [`DSP_LOCK_W-1:0] lock_cnt_reg;
  logic locked_reg;
  logic [`DSP_IMP_CNT_W-1:0] imp_cnt_reg;
  logic imp_eval;
  logic [`DSP_IMP_CODE_W-1:0] drive_code_reg;
  logic prev_rd;
  logic prev_wr;
  logic rd_busy;
  logic wr_busy;
  logic [`DSP_ADDR_W+`DSP_BEAT_W-1:0] rd_idx_a;
  logic [`DSP_ADDR_W+`DSP_BEAT_W-1:0] rd_idx_b;
  logic [`DSP_ADDR_W+`DSP_BEAT_W-1:0] wr_idx_a;
  logic [`DSP_ADDR_W+`DSP_BEAT_W-1:0] wr_idx_b;
  logic imp_up;
  logic imp_down;
  logic lock_done;

  // the command loaded on the previous edge gates both selects
  always_comb begin
    prev_rd = (prev_cmd_reg == DSP_CMD_READ);
    prev_wr = (prev_cmd_reg == DSP_CMD_WRITE);
  end

  // command decode on the rising edge
  always_comb begin
    rd_go = !load_fetch_n_i && !prev_rd;
    wr_go = !store_select_n_i && !rd_go && !prev_wr;
    if (rd_go) begin
      cmd_next = DSP_CMD_READ;
    end else if (wr_go) begin
      cmd_next = DSP_CMD_WRITE;
    end else begin
      cmd_next = DSP_CMD_DESELECT;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      prev_cmd_reg <= DSP_CMD_DESELECT;
    end else begin
      prev_cmd_reg <= cmd_next;
    end
  end

  // read port burst sequencing
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      rd_step_reg <= `DSP_STEP_IDLE;
      rd_addr_reg <= '0;
    end else begin
      case (rd_step_reg)
        `DSP_STEP_FIRST: begin
          rd_step_reg <= `DSP_STEP_SECOND;
        end
        default: begin
          if (rd_go) begin
            rd_step_reg <= `DSP_STEP_FIRST;
            rd_addr_reg <= sync_word_location_i;
          end else begin
            rd_step_reg <= `DSP_STEP_IDLE;
          end
        end
      endcase
    end
  end

  // write port burst sequencing, started only when no read starts on the same edge
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      wr_step_reg <= `DSP_STEP_IDLE;
      wr_addr_reg <= '0;
    end else begin
      case (wr_step_reg)
        `DSP_STEP_FIRST: begin
          wr_step_reg <= `DSP_STEP_SECOND;
        end
        default: begin
          if (wr_go) begin
            wr_step_reg <= `DSP_STEP_FIRST;
            wr_addr_reg <= sync_word_location_i;
          end else begin
            wr_step_reg <= `DSP_STEP_IDLE;
          end
        end
      endcase
    end
  end

  // low burst-address bits per step
  always_comb begin
    rd_beat_a = (rd_step_reg == `DSP_STEP_SECOND) ? `DSP_BEAT2 : `DSP_BEAT0;
    rd_beat_b = (rd_step_reg == `DSP_STEP_SECOND) ? `DSP_BEAT3 : `DSP_BEAT1;
    wr_beat_a = (wr_step_reg == `DSP_STEP_SECOND) ? `DSP_BEAT2 : `DSP_BEAT0;
    wr_beat_b = (wr_step_reg == `DSP_STEP_SECOND) ? `DSP_BEAT3 : `DSP_BEAT1;
  end

  // a port stays busy until its burst has moved every beat
  always_comb begin
    rd_busy = (rd_step_reg != `DSP_STEP_IDLE);
    wr_busy = (wr_step_reg != `DSP_STEP_IDLE);
  end

  // full memory indices of the two beats moved this cycle
  always_comb begin
    rd_idx_a = beat_index(rd_addr_reg, rd_beat_a);
    rd_idx_b = beat_index(rd_addr_reg, rd_beat_b);
    wr_idx_a = beat_index(wr_addr_reg, wr_beat_a);
    wr_idx_b = beat_index(wr_addr_reg, wr_beat_b);
  end

  // one storage array per 9-bit lane
  for (genvar g = 0; g < `DSP_LANES; g++) begin : g_lane
    logic [`DSP_LANE_W-1:0] lane_mem [DEPTH];
    logic wr_en_main;
    logic wr_en_comp;

    // a high mask keeps the old lane contents
    always_comb begin
      wr_en_main = wr_busy && !lane_store_masks_main_n_i[g];
      wr_en_comp = wr_busy && !lane_store_masks_comp_n_i[g];
    end

    // contents are not reset; an unwritten beat reads back unknown
    always_ff @(posedge ref_clk_i) begin
      if (wr_en_main) begin
        lane_mem[wr_idx_a] <= input_beats_main_i[g*`DSP_LANE_W +: `DSP_LANE_W];
      end
      if (wr_en_comp) begin
        lane_mem[wr_idx_b] <= input_beats_comp_i[g*`DSP_LANE_W +: `DSP_LANE_W];
      end
    end

    // a read of a beat written on the same edge returns the old data
    always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
        q_comp_reg[g] <= '0;
        q_main_reg[g] <= '0;
      end else if (rd_busy) begin
        q_comp_reg[g] <= lane_mem[rd_idx_a];
        q_main_reg[g] <= lane_mem[rd_idx_b];
      end
    end

    assign output_beats_comp_o[g*`DSP_LANE_W +: `DSP_LANE_W] = q_comp_reg[g];
    assign output_beats_main_o[g*`DSP_LANE_W +: `DSP_LANE_W] = q_main_reg[g];
  end

  // output drive and valid flag follow the read burst
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      oe_reg <= 1'b0;
      valid_reg <= 1'b0;
    end else begin
      oe_reg <= rd_busy;
      valid_reg <= rd_busy;
    end
  end

  // two-flop synchronisers for the static pins
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      loop_meta_reg <= 1'b0;
      loop_sync_reg <= 1'b0;
      zq_meta_reg <= 1'b0;
      zq_sync_reg <= 1'b0;
    end else begin
      loop_meta_reg <= timing_loop_off_n_i;
      loop_sync_reg <= loop_meta_reg;
      zq_meta_reg <= impedance_ref_pin_i;
      zq_sync_reg <= zq_meta_reg;
    end
  end

  // last count of the lock window
  always_comb begin
    lock_done = (lock_cnt_reg == `DSP_LOCK_CYCLES - 12'h1);
  end

  // loop lock timer, held clear while the loop is off
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i || !loop_sync_reg) begin
      lock_cnt_reg <= '0;
      locked_reg <= 1'b0;
    end else if (lock_done) begin
      locked_reg <= 1'b1;
    end else begin
      lock_cnt_reg <= lock_cnt_reg + 12'h1;
    end
  end

  // periodic impedance evaluation
  always_comb begin
    imp_eval = (imp_cnt_reg == `DSP_IMP_PERIOD);
  end

  // one code step per evaluation, toward the sensed optimum
  always_comb begin
    imp_up = imp_eval && (drive_code_reg < impedance_target_i);
    imp_down = imp_eval && (drive_code_reg > impedance_target_i);
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i || imp_eval) begin
      imp_cnt_reg <= '0;
    end else begin
      imp_cnt_reg <= imp_cnt_reg + 10'h1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      drive_code_reg <= `DSP_IMP_CODE_RST;
    end else if (zq_sync_reg) begin
      drive_code_reg <= `DSP_IMP_CODE_MIN_Z;
    end else if (imp_up) begin
      drive_code_reg <= drive_code_reg + 6'h1;
    end else if (imp_down) begin
      drive_code_reg <= drive_code_reg - 6'h1;
    end
  end

  assign output_beats_oe_o = oe_reg;
  assign output_valid_flag_o = valid_reg;
  assign timing_loop_locked_o = locked_reg;
  assign drive_code_o = drive_code_reg;

endmodule : dsp_sram_port

/* tb/dsp_sram_port_props.sv */
`timescale 1ns/1ps
module dsp_sram_port_props (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic load_fetch_n_i,
  input wire logic timing_loop_off_n_i,
  input wire logic impedance_ref_pin_i,
  input wire logic output_beats_oe_o,
  input wire logic output_valid_flag_o,
  input wire logic timing_loop_locked_o,
  input wire logic [5:0] drive_code_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  logic prv_rd;
  wire rd = !load_fetch_n_i && !prv_rd;
  always_ff @(posedge ref_clk_i) prv_rd <= !sys_rst_i && rd;
  AST_RD_VALID: assert property (rd |-> ##2 output_valid_flag_o[*2]) else $error("no valid");
  AST_RD_DRIVE: assert property (rd |-> ##2 output_beats_oe_o[*2]) else $error("no drive");
  AST_NO_READ: assert property (!rd ##1 !rd |-> ##2 !output_valid_flag_o) else $error("stray valid");
  AST_FLOAT: assert property (!rd ##1 !rd |-> ##2 !output_beats_oe_o) else $error("stray drive");
  AST_VALID_OE: assert property (output_valid_flag_o |-> output_beats_oe_o) else $error("valid afloat");
  AST_Z_MIN: assert property (impedance_ref_pin_i[*3] |=> drive_code_o == 6'h3f) else $error("not min");
  AST_Z_STEP: assert property (!impedance_ref_pin_i[*4] |-> 6'(drive_code_o - $past(drive_code_o) + 6'h1) <= 6'h2)
    else $error("big step");
  AST_LOOP_OFF: assert property (!timing_loop_off_n_i[*4] |-> !timing_loop_locked_o) else $error("lock");
  cover property (rd ##1 !load_fetch_n_i);
  cover property ($rose(timing_loop_locked_o));
  cover property (impedance_ref_pin_i[*3]);
endmodule : dsp_sram_port_props

bind dsp_sram_port dsp_sram_port_props i_props (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
  .load_fetch_n_i(load_fetch_n_i), .timing_loop_off_n_i(timing_loop_off_n_i),
  .impedance_ref_pin_i(impedance_ref_pin_i), .output_beats_oe_o(output_beats_oe_o),
  .output_valid_flag_o(output_valid_flag_o), .timing_loop_locked_o(timing_loop_locked_o),
  .drive_code_o(drive_code_o));

/* tb/dsp_ctl_model.sv */
`timescale 1ns/1ps
module dsp_ctl_model (
  input wire logic ref_clk_i,
  input wire logic [17:0] qm_i,
  input wire logic [17:0] qc_i,
  output logic [20:0] adr_o,
  output logic rdn_o,
  output logic wrn_o,
  output logic [17:0] dm_o,
  output logic [17:0] dc_o,
  output logic [1:0] mm_o,
  output logic [1:0] mc_o
);
  initial begin
    adr_o = 21'h0;
    rdn_o = 1'b1;
    wrn_o = 1'b1;
    {dc_o, dm_o} = 36'h0;
    {mc_o, mm_o} = 4'hf;
  end
  task automatic wr(input logic [20:0] a, input logic [71:0] d, input logic [7:0] m);
    @(negedge ref_clk_i);
    wrn_o = 1'b0;
    adr_o = a;
    for (int b = 0; b < 2; b++) begin
      @(negedge ref_clk_i);
      wrn_o = 1'b1;
      {dc_o, dm_o} = d[36*b +: 36];
      {mc_o, mm_o} = m[4*b +: 4];
    end
    @(negedge ref_clk_i);
    {dc_o, dm_o} = ~{dc_o, dm_o};
    {mc_o, mm_o} = ~{mc_o, mm_o};
  endtask : wr
  task automatic rd(input logic [20:0] a, input logic hold, output logic [71:0] q);
    @(negedge ref_clk_i);
    rdn_o = 1'b0;
    adr_o = a;
    @(negedge ref_clk_i);
    rdn_o = !hold;
    adr_o = ~a;
    @(negedge ref_clk_i);
    rdn_o = 1'b1;
    q[35:0] = {qm_i, qc_i};
    @(negedge ref_clk_i);
    q[71:36] = {qm_i, qc_i};
  endtask : rd
endmodule : dsp_ctl_model

/* tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
  typedef struct packed {
    logic [20:0] a;
    logic [71:0] d;
    logic [7:0] m;
  } dsp_row_t;
  dsp_row_t rows [4] = '{
    '{21'h000001, 72'h12_3456_789a_bcde_f012, 8'h00},
    '{21'h1fffff, 72'hfe_dcba_9876_5432_10ed, 8'h00},
    '{21'h000001, 72'ha5_5a5a_a5a5_5a5a_a5a5, 8'h46},
    '{21'h1fffff, 72'h00_0000_0000_0000_0000, 8'hff}};
  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic timing_loop_off_n_i = 1'b0;
  logic impedance_ref_pin_i = 1'b0;
  logic [5:0] impedance_target_i = 6'h21;
  wire [20:0] sync_word_location_i;
  wire load_fetch_n_i, store_select_n_i, output_beats_oe_o, output_valid_flag_o, timing_loop_locked_o;
  wire [17:0] input_beats_main_i, input_beats_comp_i, output_beats_comp_o, output_beats_main_o;
  wire [1:0] lane_store_masks_main_n_i, lane_store_masks_comp_n_i;
  wire [5:0] drive_code_o;
  logic [71:0] q;
  logic [71:0] shadow [logic [20:0]];
  int err_total = 0;
  int n_tests = 0;
  int n;
  always #20 ref_clk_i = ~ref_clk_i;
  dsp_sram_port i_dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .sync_word_location_i(sync_word_location_i),
    .load_fetch_n_i(load_fetch_n_i), .store_select_n_i(store_select_n_i), .input_beats_main_i(input_beats_main_i),
    .input_beats_comp_i(input_beats_comp_i), .lane_store_masks_main_n_i(lane_store_masks_main_n_i),
    .lane_store_masks_comp_n_i(lane_store_masks_comp_n_i), .timing_loop_off_n_i(timing_loop_off_n_i),
    .impedance_ref_pin_i(impedance_ref_pin_i), .impedance_target_i(impedance_target_i),
    .output_beats_comp_o(output_beats_comp_o), .output_beats_main_o(output_beats_main_o),
    .output_beats_oe_o(output_beats_oe_o), .output_valid_flag_o(output_valid_flag_o),
    .timing_loop_locked_o(timing_loop_locked_o), .drive_code_o(drive_code_o));
  dsp_ctl_model i_ctl (.ref_clk_i(ref_clk_i), .qm_i(output_beats_main_o), .qc_i(output_beats_comp_o),
    .adr_o(sync_word_location_i), .rdn_o(load_fetch_n_i), .wrn_o(store_select_n_i), .dm_o(input_beats_main_i),
    .dc_o(input_beats_comp_i), .mm_o(lane_store_masks_main_n_i), .mc_o(lane_store_masks_comp_n_i));
  task automatic chk(input string nm, input logic [71:0] e, input logic [71:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    #(12000 * 40);
    err_total++;
    tally_and_finish();
  end
  initial begin
    repeat (3) @(negedge ref_clk_i);
    sys_rst_i = 1'b0;
    chk("reset", 72'h20, {63'h0, output_beats_oe_o, output_valid_flag_o, timing_loop_locked_o, drive_code_o});
    timing_loop_off_n_i = 1'b1;
    n = 0;
    while (timing_loop_locked_o !== 1'b1 && n < 3000) begin
      @(negedge ref_clk_i);
      n++;
    end
    chk("lock", 72'h1, 72'(n >= 2048 && n < 2056));
    foreach (rows[r]) begin
      i_ctl.wr(rows[r].a, rows[r].d, rows[r].m);
      for (int l = 0; l < 8; l++) begin
        if (!rows[r].m[l]) shadow[rows[r].a][9*l +: 9] = rows[r].d[9*l +: 9];
      end
      i_ctl.rd(rows[r].a, 1'b0, q);
      chk("row", shadow[rows[r].a], q);
    end
    fork
      i_ctl.wr(21'h0aaaa5, 72'h3c_c3c3_3c3c_c3c3_3c3c, 8'h00);
      begin
        @(negedge ref_clk_i);
        i_ctl.rd(21'h1, 1'b0, q);
      end
    join
    chk("overlap", shadow[21'h1], q);
    i_ctl.rd(21'h0aaaa5, 1'b0, q);
    chk("burst", 72'h3c_c3c3_3c3c_c3c3_3c3c, q);
    i_ctl.rd(21'h1fffff, 1'b1, q);
    chk("held", shadow[21'h1fffff], q);
    @(negedge ref_clk_i);
    chk("ignored", 72'h0, {70'h0, output_valid_flag_o, output_beats_oe_o});
    timing_loop_off_n_i = 1'b0;
    repeat (4) @(negedge ref_clk_i);
    chk("unlock", 72'h0, 72'(timing_loop_locked_o));
    impedance_ref_pin_i = 1'b1;
    repeat (4) @(negedge ref_clk_i);
    chk("zmin", 72'h3f, 72'(drive_code_o));
    impedance_ref_pin_i = 1'b0;
    impedance_target_i = 6'h3d;
    repeat (1000) @(negedge ref_clk_i);
    chk("zstep", 72'h1, 72'(drive_code_o >= 6'h3e));
    repeat (2100) @(negedge ref_clk_i);
    chk("zend", 72'h3d, 72'(drive_code_o));
    tally_and_finish();
  end
endmodule : testbench
